// file: common/async_strobe_defines.vh
/*
  Constants for the asynchronous memory strobe sequencer: timing counts,
  idle levels and reset values.
  Assumes the includer runs on one system clock.
*/
// Operation
// (R1) read without extended wait lasts read setup plus strobe plus hold cycles
// (R2) read with extended wait adds sixteen cycles per external wait count
// (R3) output enable stays low exactly read strobe cycles without extended wait
// (R4) output enable low time gains sixteen cycles per wait count when extended
// (R5) select strobe mode makes chip select follow the strobe exactly
// (R6) otherwise chip select leads by setup cycles, trails by hold cycles
// (R7) read address and bank valid read setup cycles before output enable falls
// (R8) read address and bank held read hold cycles after output enable rises
// (R9) write without extended wait lasts write setup plus strobe plus hold cycles
// (R10) write with extended wait adds sixteen cycles per external wait count
// (R11) write address valid setup cycles before strobe, held hold cycles after
// (R12) write bank address valid setup cycles before, held hold cycles after
// (R13) output enable rises four cycles after wait input is released
// (R14) memory asserts wait at least four cycles before hold would start
// (R15) programmed turnaround idle cycles are inserted between accesses
// (R16) all phase counts and maximum wait come from configuration inputs
// (R17) write strobe low time is strobe count plus sixteen per wait count
// (R18) write strobe rises about four cycles after wait input is released
// (R19) wait count ranges 1 to 256, limited by programmed maximum wait count
// (R20) wait input is sampled only in strobe phase with extended wait enabled
`ifndef ASYNC_STROBE_DEFINES_VH
`define ASYNC_STROBE_DEFINES_VH

// ----------------------------------------------------------------------
// timing counts, in system clock cycles
// ----------------------------------------------------------------------
`define EXT_WAIT_UNIT_CYC   16
`define EXT_WAIT_UNIT_LAST  4'hf
`define WAIT_RELEASE_CYC    4
`define SYNC_STAGES         2

// ----------------------------------------------------------------------
// idle levels and reset values
// ----------------------------------------------------------------------
`define CS_IDLE_N           4'hf
`define STROBE_IDLE_N       1'b1
`define ADDR_RESET          21'h000000
`define BANK_RESET          2'h0
`define DATA_RESET          16'h0000

`endif

// file: rtl/async_strobe_seq.v
/*
  Asynchronous memory strobe sequencer: setup, strobe, hold and turnaround
  phases for reads and writes to SRAM or NOR flash, with extended wait.
  Assumes configuration inputs are stable while an access runs, and that the
  wait and data pins are asynchronous to the system clock.
*/
`timescale 1ns/100ps
`include "async_strobe_defines.vh"

module async_strobe_seq #(
  parameter CNT_W = 8
) (
  // clock and reset
  input  wire             sys_clk_i,
  input  wire             sys_rst_i,
  // access request
  input  wire             req_valid_i,
  input  wire             req_write_i,
  input  wire [1:0]       req_cs_i,
  input  wire [20:0]      req_addr_i,
  input  wire [1:0]       req_bank_i,
  input  wire [15:0]      req_wdata_i,
  output reg              req_ready_o,
  output reg              done_o,
  output reg              timeout_o,
  output reg  [15:0]      rdata_o,
  // configuration
  input  wire             extended_wait_enable_i,
  input  wire             select_strobe_i,
  input  wire [CNT_W-1:0] turnaround_cycles_i,
  input  wire [CNT_W-1:0] read_setup_cycles_i,
  input  wire [CNT_W-1:0] read_strobe_cycles_i,
  input  wire [CNT_W-1:0] read_hold_cycles_i,
  input  wire [CNT_W-1:0] write_setup_cycles_i,
  input  wire [CNT_W-1:0] write_strobe_cycles_i,
  input  wire [CNT_W-1:0] write_hold_cycles_i,
  input  wire [7:0]       max_wait_count_i,
  // memory pins
  output reg  [3:0]       async_chip_select_n_o,
  output reg              read_output_enable_n_o,
  output reg              write_strobe_n_o,
  output reg  [20:0]      word_address_out_o,
  output reg  [1:0]       bank_address_out_o,
  output reg  [15:0]      memory_data_bus_o,
  output reg              memory_data_bus_oe_o,
  input  wire [15:0]      memory_data_bus_i,
  input  wire             external_wait_in_i
);

  // ----------------------------------------------------------------------
  // states, one-hot
  // ----------------------------------------------------------------------
  localparam [6:0] S_IDLE    = 7'h01;
  localparam [6:0] S_SETUP   = 7'h02;
  localparam [6:0] S_STROBE  = 7'h04;
  localparam [6:0] S_EXTEND  = 7'h08;
  localparam [6:0] S_RELEASE = 7'h10;
  localparam [6:0] S_HOLD    = 7'h20;
  localparam [6:0] S_TURN    = 7'h40;

  localparam [3:0] UNIT_LAST = `EXT_WAIT_UNIT_LAST;

  // a count of zero still gives one cycle; only turnaround skips its phase at zero
  function [CNT_W-1:0] load_of;
    input [CNT_W-1:0] cycles;
    begin
      load_of = (cycles == {CNT_W{1'b0}}) ? {CNT_W{1'b0}} : cycles - 1'b1;
    end
  endfunction

  // chip select pattern for the latched select line
  function [3:0] cs_decode;
    input [1:0] sel;
    begin
      cs_decode = ~(4'h1 << sel);
    end
  endfunction

  reg  [6:0]       state;
  reg  [6:0]       next_state;
  reg  [CNT_W-1:0] cnt;
  reg  [CNT_W-1:0] next_cnt;
  reg  [3:0]       unit_cnt;
  reg  [8:0]       wait_count;
  reg              wait_seen;
  reg              is_write;
  reg  [1:0]       cs_sel;
  reg  [15:0]      wdata;
  reg              wait_ff1;
  reg              wait_s;
  reg  [15:0]      data_ff1;
  reg  [15:0]      data_s;
  reg              next_timeout;

  wire accept    = req_valid_i & req_ready_o;
  wire unit_end  = (unit_cnt == UNIT_LAST);
  wire wait_max  = (wait_count == ({1'b0, max_wait_count_i} + 9'h001));
  wire [CNT_W-1:0] strobe_cfg = is_write ? write_strobe_cycles_i : read_strobe_cycles_i;
  wire [CNT_W-1:0] hold_cfg   = is_write ? write_hold_cycles_i : read_hold_cycles_i;

  // ----------------------------------------------------------------------
  // pin synchronisers
  // ----------------------------------------------------------------------
  // two stages on wait and read data; first stage read by nothing else
  always @(posedge sys_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      wait_ff1 <= 1'b0;
      wait_s   <= 1'b0;
      data_ff1 <= `DATA_RESET;
      data_s   <= `DATA_RESET;
    end else begin
      wait_ff1 <= external_wait_in_i;
      wait_s   <= wait_ff1;
      data_ff1 <= memory_data_bus_i;
      data_s   <= data_ff1;
    end
  end

  // ----------------------------------------------------------------------
  // phase sequencing
  // ----------------------------------------------------------------------
  // next state and phase counter
  always @* begin
    next_state   = state;
    next_cnt     = cnt;
    next_timeout = 1'b0;
    case (state)
      S_IDLE: begin
        if (accept) begin
          // (R16) counts from configuration
          next_state = S_SETUP;
          next_cnt   = load_of(req_write_i ? write_setup_cycles_i : read_setup_cycles_i);
        end
      end
      S_SETUP: begin
        // (R7) address before strobe
        if (cnt == {CNT_W{1'b0}}) begin
          next_state = S_STROBE;
          next_cnt   = load_of(strobe_cfg);
        end else begin
          next_cnt = cnt - 1'b1;
        end
      end
      S_STROBE: begin
        // (R3) strobe length exact
        if (cnt == {CNT_W{1'b0}}) begin
          // (R14) wait must be seen before strobe end
          if (extended_wait_enable_i && (wait_seen || wait_s)) begin
            next_state = S_EXTEND;
          end else begin
            next_state = S_HOLD;
            next_cnt   = load_of(hold_cfg);
          end
        end else begin
          next_cnt = cnt - 1'b1;
        end
      end
      S_EXTEND: begin
        // (R19) timeout at programmed maximum
        if (!wait_s) begin
          next_state = S_RELEASE;
        end else if (unit_end && wait_max) begin
          next_state   = S_HOLD;
          next_cnt     = load_of(hold_cfg);
          next_timeout = 1'b1;
        end
      end
      S_RELEASE: begin
        // (R13) (R18) strobe rises four cycles after release
        next_state = S_HOLD;
        next_cnt   = load_of(hold_cfg);
      end
      S_HOLD: begin
        // (R8) address held through hold
        if (cnt == {CNT_W{1'b0}}) begin
          next_cnt = load_of(turnaround_cycles_i);
          if (turnaround_cycles_i == {CNT_W{1'b0}}) begin
            next_state = S_IDLE;
          end else begin
            next_state = S_TURN;
          end
        end else begin
          next_cnt = cnt - 1'b1;
        end
      end
      S_TURN: begin
        // (R15) idle gap between accesses
        if (cnt == {CNT_W{1'b0}}) begin
          next_state = S_IDLE;
        end else begin
          next_cnt = cnt - 1'b1;
        end
      end
      default: begin
        next_state = S_IDLE;
        next_cnt   = {CNT_W{1'b0}};
      end
    endcase
  end

  // state, counters and latched request
  always @(posedge sys_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      state      <= S_IDLE;
      cnt        <= {CNT_W{1'b0}};
      unit_cnt   <= 4'h0;
      wait_count <= 9'h000;
      wait_seen  <= 1'b0;
      is_write   <= 1'b0;
      cs_sel     <= 2'h0;
      wdata      <= `DATA_RESET;
    end else begin
      state <= next_state;
      cnt   <= next_cnt;
      if (accept) begin
        is_write <= req_write_i;
        cs_sel   <= req_cs_i;
        wdata    <= req_wdata_i;
      end
      // (R20) wait sampled only in strobe with extension on
      if (state == S_STROBE) begin
        wait_seen <= wait_seen | (extended_wait_enable_i & wait_s);
      end else if (state == S_IDLE) begin
        wait_seen <= 1'b0;
      end
      // (R2) sixteen-cycle wait units counted
      if (state == S_EXTEND) begin
        unit_cnt <= unit_cnt + 4'h1;
        if (unit_end) begin
          wait_count <= wait_count + 9'h001;
        end
      end else if (state == S_STROBE) begin
        unit_cnt   <= 4'h0;
        wait_count <= 9'h001;
      end
    end
  end

  // ----------------------------------------------------------------------
  // registered pin and status outputs
  // ----------------------------------------------------------------------
  // outputs decoded from next state so pins change on the phase edge
  always @(posedge sys_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      req_ready_o            <= 1'b0;
      done_o                 <= 1'b0;
      timeout_o              <= 1'b0;
      rdata_o                <= `DATA_RESET;
      async_chip_select_n_o  <= `CS_IDLE_N;
      read_output_enable_n_o <= `STROBE_IDLE_N;
      write_strobe_n_o       <= `STROBE_IDLE_N;
      word_address_out_o     <= `ADDR_RESET;
      bank_address_out_o     <= `BANK_RESET;
      memory_data_bus_o      <= `DATA_RESET;
      memory_data_bus_oe_o   <= 1'b0;
    end else begin
      req_ready_o <= (next_state == S_IDLE);
      done_o      <= (state == S_HOLD) && (next_state != S_HOLD);
      timeout_o   <= next_timeout;
      // (R11) (R12) address and bank latched for the whole access
      if (accept) begin
        word_address_out_o <= req_addr_i;
        bank_address_out_o <= req_bank_i;
      end
      // (R4) (R17) strobe low over strobe and extension
      if (next_state == S_STROBE || next_state == S_EXTEND || next_state == S_RELEASE) begin
        read_output_enable_n_o <= (accept ? req_write_i : is_write);
        write_strobe_n_o       <= ~(accept ? req_write_i : is_write);
      end else begin
        read_output_enable_n_o <= `STROBE_IDLE_N;
        write_strobe_n_o       <= `STROBE_IDLE_N;
      end
      // (R5) (R6) chip select with or without setup and hold
      if (next_state == S_STROBE || next_state == S_EXTEND || next_state == S_RELEASE ||
          (!select_strobe_i && (next_state == S_SETUP || next_state == S_HOLD))) begin
        async_chip_select_n_o <= cs_decode(accept ? req_cs_i : cs_sel);
      end else begin
        async_chip_select_n_o <= `CS_IDLE_N;
      end
      // write data driven setup through hold
      memory_data_bus_oe_o <= (accept ? req_write_i : is_write) &&
                              (next_state == S_SETUP || next_state == S_STROBE ||
                               next_state == S_EXTEND || next_state == S_RELEASE ||
                               next_state == S_HOLD);
      if (accept) begin
        memory_data_bus_o <= req_wdata_i;
      end
      // (R1) (R9) (R10) read data taken as the strobe phase closes
      if (!is_write && state != S_HOLD && next_state == S_HOLD) begin
        rdata_o <= data_s;
      end
    end
  end

endmodule // async_strobe_seq

// file: tb/async_strobe_seq_asserts.sv
/*
  Timing checker for the strobe sequencer pins.
  Assumes one clock and configuration held steady during an access.
*/
`timescale 1ns/100ps
module async_strobe_seq_asserts #(
  parameter CNT_W = 8
) (
  // clock and status
  input wire             sys_clk_i,
  input wire             sys_rst_i,
  input wire             done_o,
  // configuration
  input wire             extended_wait_enable_i,
  input wire             select_strobe_i,
  input wire [CNT_W-1:0] turnaround_cycles_i,
  input wire [CNT_W-1:0] read_setup_cycles_i,
  input wire [CNT_W-1:0] read_strobe_cycles_i,
  input wire [CNT_W-1:0] read_hold_cycles_i,
  input wire [CNT_W-1:0] write_setup_cycles_i,
  input wire [CNT_W-1:0] write_strobe_cycles_i,
  input wire [CNT_W-1:0] write_hold_cycles_i,
  // memory pins
  input wire [3:0]       async_chip_select_n_o,
  input wire             read_output_enable_n_o,
  input wire             write_strobe_n_o,
  input wire [20:0]      word_address_out_o,
  input wire [1:0]       bank_address_out_o,
  input wire             external_wait_in_i
);
  wire       cs_act = (async_chip_select_n_o != 4'hf);
  reg [15:0] cs_cnt, oe_cnt, we_cnt, idle_cnt;
  reg        last_wr;
  // run lengths of each pin level; idle starts saturated so reset is no gap
  always @(posedge sys_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      {cs_cnt, oe_cnt, we_cnt} <= 48'h0;
      idle_cnt <= 16'hffff;
      last_wr  <= 1'b0;
    end else begin
      cs_cnt   <= cs_act ? cs_cnt + 16'h1 : 16'h0;
      oe_cnt   <= read_output_enable_n_o ? 16'h0 : oe_cnt + 16'h1;
      we_cnt   <= write_strobe_n_o ? 16'h0 : we_cnt + 16'h1;
      idle_cnt <= cs_act ? 16'h0 : idle_cnt + {15'h0, idle_cnt != 16'hffff};
      if (!write_strobe_n_o) last_wr <= 1'b1;
      else if (!read_output_enable_n_o) last_wr <= 1'b0;
    end
  end
  default clocking @(posedge sys_clk_i); endclocking
  default disable iff (sys_rst_i);
  a_oe_low_width: assert property ($rose(read_output_enable_n_o)
    && !extended_wait_enable_i |-> oe_cnt == read_strobe_cycles_i)
    else $error("read strobe width wrong");
  a_we_low_width: assert property ($rose(write_strobe_n_o)
    && !extended_wait_enable_i |-> we_cnt == write_strobe_cycles_i)
    else $error("write strobe width wrong");
  a_read_setup: assert property ($fell(read_output_enable_n_o) && !select_strobe_i
    |-> cs_cnt == read_setup_cycles_i) else $error("read setup wrong");
  a_write_setup: assert property ($fell(write_strobe_n_o) && !select_strobe_i
    |-> cs_cnt == write_setup_cycles_i) else $error("write setup wrong");
  a_cycle_length: assert property ($fell(cs_act) && !select_strobe_i
    && !extended_wait_enable_i
    |-> cs_cnt == (last_wr ? write_setup_cycles_i + write_strobe_cycles_i + write_hold_cycles_i
                   : read_setup_cycles_i + read_strobe_cycles_i + read_hold_cycles_i))
    else $error("access length wrong");
  a_select_follow: assert property (select_strobe_i
    |-> cs_act == (!read_output_enable_n_o || !write_strobe_n_o))
    else $error("select not strobe");
  a_addr_steady: assert property (cs_act && $past(cs_act)
    |-> $stable(word_address_out_o) && $stable(bank_address_out_o))
    else $error("address moved");
  a_wait_release: assert property (extended_wait_enable_i && $fell(external_wait_in_i)
    && !(read_output_enable_n_o && write_strobe_n_o)
    |-> ##[3:5] ($rose(read_output_enable_n_o) || $rose(write_strobe_n_o)))
    else $error("strobe late after wait");
  a_turnaround: assert property ($rose(cs_act) |-> idle_cnt >= turnaround_cycles_i)
    else $error("turnaround too short");
  a_done_pulse: assert property (done_o |=> !done_o) else $error("done too long");
endmodule // async_strobe_seq_asserts

bind async_strobe_seq async_strobe_seq_asserts #(.CNT_W(CNT_W)) u_chk (.*);

// file: tb/sram_model.sv
/*
  Behavioural asynchronous memory with a wait output.
  Assumes pins registered on the same clock; 16 words decoded.
*/
`timescale 1ns/100ps
module sram_model (
  // pins
  input  wire        clk_i,
  input  wire [3:0]  cs_n_i,
  input  wire        oe_n_i,
  input  wire        we_n_i,
  input  wire [20:0] addr_i,
  input  wire [15:0] data_i,
  input  wire [7:0]  wait_len_i,
  output wire [15:0] data_o,
  output reg         wait_o
);
  reg [15:0] mem [0:15];
  reg [15:0] last = 16'h0;
  reg [7:0]  wcnt = 8'h0;
  reg        cs_q = 1'b0;
  wire       sel  = (cs_n_i != 4'hf);
  initial wait_o = 1'b0;
  // undriven bus shows inverted last value, never a stale copy
  assign data_o = (sel && !oe_n_i) ? mem[addr_i[3:0]] : ~last;
  // write latched while strobe low; wait raised at select, before strobe ends
  // early wait
  always @(posedge clk_i) begin
    cs_q <= sel;
    if (sel && !oe_n_i) last <= mem[addr_i[3:0]];
    if (sel && !we_n_i) mem[addr_i[3:0]] <= data_i;
    if (sel && !cs_q && wait_len_i != 8'h0) begin
      wait_o <= 1'b1;
      wcnt   <= wait_len_i;
    end else if (wcnt != 8'h0) wcnt <= wcnt - 8'h1;
    else wait_o <= 1'b0;
  end
endmodule // sram_model

// file: tb/async_strobe_seq_tb.sv
/*
  Self-checking bench for the strobe sequencer.
  Assumes a 40 MHz clock and the memory model on the pins.
*/
`timescale 1ns/100ps
module async_strobe_seq_tb;
  typedef struct {bit w; bit [1:0] c; bit ss; logic [20:0] a; logic [15:0] d;} row_t;
  row_t rows [8] = '{'{1,0,0,21'h000001,16'h1234}, '{1,1,1,21'h0a0002,16'hbeef},
    '{1,2,0,21'h1f0003,16'h00ff}, '{1,3,1,21'h05500f,16'ha5a5}, '{0,0,1,21'h000001,16'h1234},
    '{0,1,0,21'h0a0002,16'hbeef}, '{0,2,1,21'h1f0003,16'h00ff}, '{0,3,0,21'h05500f,16'ha5a5}};
  logic        sys_clk_i = 0, sys_rst_i = 1, req_valid_i = 0, req_write_i = 0;
  logic [1:0]  req_cs_i = 0, req_bank_i = 0;
  logic [20:0] req_addr_i = 0;
  logic [15:0] req_wdata_i = 0;
  logic        extended_wait_enable_i = 0, select_strobe_i = 0;
  logic [7:0]  turnaround_cycles_i = 2, read_setup_cycles_i = 2, read_strobe_cycles_i = 4;
  logic [7:0]  read_hold_cycles_i = 1, write_setup_cycles_i = 1, write_strobe_cycles_i = 3;
  logic [7:0]  write_hold_cycles_i = 2, max_wait_count_i = 1, wait_len = 0;
  wire         req_ready_o, done_o, timeout_o, read_output_enable_n_o, write_strobe_n_o;
  wire         memory_data_bus_oe_o, external_wait_in_i;
  wire [15:0]  rdata_o, memory_data_bus_o, memory_data_bus_i;
  wire [3:0]   async_chip_select_n_o;
  wire [20:0]  word_address_out_o;
  wire [1:0]   bank_address_out_o;
  integer      err_count = 0, tests_run = 0, cyc = 0, lowc, i, k;
  bit          tmo;
  always #12.5 sys_clk_i = ~sys_clk_i;
  async_strobe_seq DUT (.*);
  sram_model mem (.clk_i(sys_clk_i), .cs_n_i(async_chip_select_n_o),
    .oe_n_i(read_output_enable_n_o), .we_n_i(write_strobe_n_o), .addr_i(word_address_out_o),
    .data_i(memory_data_bus_o), .wait_len_i(wait_len), .data_o(memory_data_bus_i),
    .wait_o(external_wait_in_i));
  // hang guard, well beyond the few hundred cycles needed
  always @(posedge sys_clk_i) begin
    cyc++;
    if (cyc == 20000) begin
      err_count++;
      summarize;
    end
  end
  task chk(input logic ok);
    tests_run++;
    if (ok !== 1'b1) begin
      err_count++;
      $display("unexpected at %0t: value mismatch", $time);
    end
  endtask
  // one access: wait ready, hand over, watch strobe until done
  task acc(input bit w, input [1:0] c, input [20:0] a, input [15:0] d);
    integer n;
    begin
      @(posedge sys_clk_i); #2;
      {req_valid_i, req_write_i, req_cs_i} = {1'b1, w, c};
      {req_addr_i, req_bank_i, req_wdata_i} = {a, a[1:0], d};
      n = 0;
      while (req_ready_o !== 1'b1 && n < 100) begin @(posedge sys_clk_i); #2; n++; end
      chk(n < 100);
      @(posedge sys_clk_i); #2;
      req_valid_i = 0;
      {lowc, tmo, n} = 0;
      while (done_o !== 1'b1 && n < 1000) begin
        if ((w ? write_strobe_n_o : read_output_enable_n_o) === 1'b0) begin
          lowc++;
          if (lowc == 1) begin
            chk(word_address_out_o === a && bank_address_out_o === a[1:0]);
            chk(async_chip_select_n_o === ~(4'h1 << c));
            chk(!w || memory_data_bus_o === d && memory_data_bus_oe_o === 1'b1);
          end
        end
        if (timeout_o === 1'b1) tmo = 1;
        @(posedge sys_clk_i); #2; n++;
      end
      chk(n < 1000);
    end
  endtask
  task summarize;
    $display("checks %0d errors %0d", tests_run, err_count);
    if (err_count == 0 && tests_run > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  initial begin
    repeat (16) @(posedge sys_clk_i); #2;
    sys_rst_i = 0;
    // table rows under two timing sets; the second has no turnaround gap
    for (k = 0; k < 2; k++) begin
      if (k) begin
        {turnaround_cycles_i, read_setup_cycles_i, read_strobe_cycles_i} = {8'd0, 8'd1, 8'd3};
        {read_hold_cycles_i, write_setup_cycles_i} = {8'd3, 8'd3};
        {write_strobe_cycles_i, write_hold_cycles_i} = {8'd4, 8'd1};
      end
      for (i = 0; i < 8; i++) begin
        select_strobe_i = rows[i].ss;
        acc(rows[i].w, rows[i].c, rows[i].a, rows[i].d);
        chk(lowc === (rows[i].w ? write_strobe_cycles_i : read_strobe_cycles_i));
        if (!rows[i].w) chk(rdata_o === rows[i].d);
      end
    end
    // extended wait stretches the strobe, then a wait that runs into timeout
    {select_strobe_i, read_setup_cycles_i, read_strobe_cycles_i} = {1'b0, 8'd2, 8'd4};
    {extended_wait_enable_i, wait_len} = {1'b1, 8'd20};
    acc(0, 1, 21'h0a0002, 16'h0);
    chk(lowc > 16 && rdata_o === 16'hbeef && !tmo);
    {max_wait_count_i, wait_len} = {8'd0, 8'd200};
    acc(1, 2, 21'h1f0003, 16'h5a5a);
    chk(tmo === 1'b1);
    repeat (210) @(posedge sys_clk_i); #2;
    // wait ignored when extension is off
    {extended_wait_enable_i, wait_len} = {1'b0, 8'd40};
    acc(0, 2, 21'h1f0003, 16'h0);
    chk(lowc === 4 && rdata_o === 16'h5a5a);
    repeat (50) @(posedge sys_clk_i); #2;
    wait_len = 0;
    // reset in mid access returns pins to idle
    req_valid_i = 1;
    repeat (3) @(posedge sys_clk_i); #2;
    {sys_rst_i, req_valid_i} = 2'b10;
    #1 chk(async_chip_select_n_o === 4'hf && memory_data_bus_oe_o === 1'b0);
    chk(read_output_enable_n_o === 1'b1 && write_strobe_n_o === 1'b1);
    chk(req_ready_o === 1'b0);
    repeat (2) @(posedge sys_clk_i); #2;
    sys_rst_i = 0;
    acc(0, 3, 21'h05500f, 16'h0);
    chk(rdata_o === 16'ha5a5);
    summarize;
  end
endmodule // async_strobe_seq_tb
